// file: rtl/dual_clock_fifo_1024x18.sv
// top of the 1024 x 18 buffer: pin sampling, pointers, flags, offset, bus slave
// assumes pin clocks are much slower than clk (several clk periods per phase)
// and that write data are stable for some clk periods around a write edge
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - store 1024 words of 18 bits
// - clocks may be unrelated or the same
// - write edge stores data unless full
// - read edge advances head unless empty
// - full when written minus read is 1024
// - write edges while full or read edges while empty change nothing
// - active-low full and empty outputs
// - half flag high at 512 or more words
// - near flag at X or less, 1024-X up
// - low reset clears pointers, sets flag levels
// - reset leaves read data undefined
// - output enable low floats read data
// - first word falls through to outputs
// - offset reloaded on every reset cycle
// - strobe fall captures write data as candidate
// - candidate taken from data bits 0 to 8
// - strobe high through reset picks 256
module dual_clock_fifo_1024x18
  import fifo_pkg::*;
(
  // system clock and reset
  input wire logic clk,
  input wire logic rst,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // buffer control pins
  input wire logic write_clock,
  input wire logic read_clock,
  input wire logic fifo_reset_n,
  input wire logic offset_define_strobe_n,
  input wire logic output_enable,
  // buffer data pins
  input wire logic [DATA_W-1:0] write_data_in,
  output logic [DATA_W-1:0] read_data_out,
  output logic read_data_oe,
  // status pins
  output logic full_n,
  output logic empty_n,
  output logic half_level_flag,
  output logic near_limit_flag
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [PIN_COUNT-1:0] ctl_s2;
  logic [PIN_COUNT-1:0] ctl_s3;
  logic [PIN_COUNT-1:0] lvl_ff;
  logic [PIN_COUNT-1:0] nxt_lvl;
  logic [PIN_COUNT-1:0] pin_rise;
  logic [PIN_COUNT-1:0] pin_fall;
  logic [DATA_W-1:0] din_s3;
  logic in_reset;
  logic fifo_clear;
  reset_state_e state_ff;
  reset_state_e nxt_state;
  logic reset_release;
  logic [OFFSET_W-1:0] candidate_ff;
  logic [OFFSET_W-1:0] nxt_candidate;
  logic [OFFSET_W-1:0] offset_active_ff;
  logic [PTR_W-1:0] wr_cnt_ff;
  logic [PTR_W-1:0] rd_cnt_ff;
  logic [PTR_W-1:0] wr_sync1_ff;
  logic [PTR_W-1:0] wr_sync2_ff;
  logic [PTR_W-1:0] rd_sync1_ff;
  logic [PTR_W-1:0] rd_sync2_ff;
  logic [PTR_W-1:0] fill_now;
  logic [PTR_W-1:0] near_high;
  logic write_go;
  logic read_go;
  logic full_n_ff;
  logic empty_n_ff;
  logic half_ff;
  logic near_ff;
  logic aw_held_ff;
  logic [7:0] awaddr_ff;
  logic w_held_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic ctrl_hold_ff;
  logic do_write;
  logic [31:0] read_word;
  logic [1:0] read_resp;

  mem_if mem ();

  // ****************************************************************
  // pin sampling
  // ****************************************************************

  // control pins: clocks, reset, strobe, enable
  pin_sync #(
    .W(PIN_COUNT)
  ) u_ctl_sync (
    .clk(clk),
    .rst(rst),
    .pin_in({output_enable, offset_define_strobe_n, fifo_reset_n, read_clock, write_clock}),
    .stage2(ctl_s2),
    .stage3(ctl_s3)
  );

  // data pins share the delay so they line up with the clock edge
  pin_sync #(
    .W(DATA_W)
  ) u_din_sync (
    .clk(clk),
    .rst(rst),
    .pin_in(write_data_in),
    .stage2(),
    .stage3(din_s3)
  );

  // a change counts once the second and third stage agree
  always_comb
  begin
    nxt_lvl = (ctl_s2 & ctl_s3) | (lvl_ff & (ctl_s2 ^ ctl_s3));
    pin_rise = nxt_lvl & ~lvl_ff;
    pin_fall = ~nxt_lvl & lvl_ff;
  end

  // filtered pin levels
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lvl_ff <= PIN_LEVEL_RESET;
    end
    else
    begin
      lvl_ff <= nxt_lvl;
    end
  end

  // ****************************************************************
  // buffer reset and offset
  // ****************************************************************

  // pin reset or software hold both act as the buffer reset
  assign in_reset = ~lvl_ff[PIN_RST_N] | ctrl_hold_ff;
  assign fifo_clear = rst | in_reset;
  assign reset_release = (state_ff == ST_RESET) && !in_reset;

  // reset cycle tracking
  always_comb
  begin
    case (state_ff)
      ST_RUN: nxt_state = in_reset ? ST_RESET : ST_RUN;
      ST_RESET: nxt_state = in_reset ? ST_RESET : ST_RUN;
      default: nxt_state = ST_RESET;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_ff <= ST_RESET;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // strobe fall latches low data bits at any time
  always_comb
  begin
    nxt_candidate = candidate_ff;
    if (pin_fall[PIN_STROBE_N])
    begin
      nxt_candidate = din_s3[OFFSET_W-1:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      candidate_ff <= DEFAULT_OFFSET;
    end
    else
    begin
      candidate_ff <= nxt_candidate;
    end
  end

  // applied offset moves only when a reset cycle ends
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      offset_active_ff <= DEFAULT_OFFSET;
    end
    else if (reset_release)
    begin
      if (lvl_ff[PIN_STROBE_N])
      begin
        offset_active_ff <= DEFAULT_OFFSET;
      end
      else
      begin
        offset_active_ff <= nxt_candidate;
      end
    end
  end

  // ****************************************************************
  // pointers
  // ****************************************************************

  // writes judge fullness against the twice-registered read count
  assign write_go = pin_rise[PIN_WCLK] && !fifo_clear
    && (fill_count(wr_cnt_ff, rd_sync2_ff) != FULL_LEVEL);
  // reads judge emptiness against the twice-registered write count
  assign read_go = pin_rise[PIN_RCLK] && !fifo_clear
    && (wr_sync2_ff != rd_cnt_ff);

  always_ff @(posedge clk)
  begin
    if (fifo_clear)
    begin
      wr_cnt_ff <= '0;
    end
    else if (write_go)
    begin
      wr_cnt_ff <= wr_cnt_ff + 11'h001;
    end
  end

  always_ff @(posedge clk)
  begin
    if (fifo_clear)
    begin
      rd_cnt_ff <= '0;
    end
    else if (read_go)
    begin
      rd_cnt_ff <= rd_cnt_ff + 11'h001;
    end
  end

  // stale far counts only ever make a flag pessimistic, never wrong
  always_ff @(posedge clk)
  begin
    if (fifo_clear)
    begin
      wr_sync1_ff <= '0;
      wr_sync2_ff <= '0;
      rd_sync1_ff <= '0;
      rd_sync2_ff <= '0;
    end
    else
    begin
      wr_sync1_ff <= wr_cnt_ff;
      wr_sync2_ff <= wr_sync1_ff;
      rd_sync1_ff <= rd_cnt_ff;
      rd_sync2_ff <= rd_sync1_ff;
    end
  end

  // memory port: head word is always on the read address
  assign mem.we = write_go;
  assign mem.waddr = wr_cnt_ff[ADDR_W-1:0];
  assign mem.wdata = din_s3;
  assign mem.raddr = rd_cnt_ff[ADDR_W-1:0];

  fifo_mem u_mem (
    .clk(clk),
    .port(mem.store)
  );

  // ****************************************************************
  // flags
  // ****************************************************************
  assign fill_now = fill_count(wr_cnt_ff, rd_cnt_ff);
  assign near_high = FULL_LEVEL - {2'b00, offset_active_ff};

  always_ff @(posedge clk)
  begin
    if (fifo_clear)
    begin
      full_n_ff <= 1'b1;
      empty_n_ff <= 1'b0;
      half_ff <= 1'b0;
      near_ff <= 1'b1;
    end
    else
    begin
      full_n_ff <= fill_count(wr_cnt_ff, rd_sync2_ff) != FULL_LEVEL;
      empty_n_ff <= wr_sync2_ff != rd_cnt_ff;
      half_ff <= fill_now >= HALF_LEVEL;
      near_ff <= (fill_now <= {2'b00, offset_active_ff}) || (fill_now >= near_high);
    end
  end

  assign full_n = full_n_ff;
  assign empty_n = empty_n_ff;
  assign half_level_flag = half_ff;
  assign near_limit_flag = near_ff;
  // data straight from the memory read register, never reset
  assign read_data_out = mem.rdata;
  assign read_data_oe = lvl_ff[PIN_OE];

  // ****************************************************************
  // axi4-lite slave
  // ****************************************************************

  // one write and one read at a time; channels stall while answering
  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready = !w_held_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;

  // address and data are taken in either order
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      aw_held_ff <= 1'b0;
      awaddr_ff <= 8'h00;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr;
    end
    else if (do_write)
    begin
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      w_held_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_ff <= 1'b1;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end
    else if (do_write)
    begin
      w_held_ff <= 1'b0;
    end
  end

  // write response; read-only registers accept and ignore writes
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_ff <= 1'b1;
      case ({awaddr_ff[7:2], 2'b00})
        REG_STATUS: bresp_ff <= RESP_OKAY;
        REG_CTRL: bresp_ff <= RESP_OKAY;
        REG_OFFSET: bresp_ff <= RESP_OKAY;
        default: bresp_ff <= RESP_SLVERR;
      endcase
    end
    else if (s_axi_bready)
    begin
      bvalid_ff <= 1'b0;
    end
  end

  // software hold keeps the buffer in reset
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_hold_ff <= CTRL_HOLD_RESET;
    end
    else if (do_write && ({awaddr_ff[7:2], 2'b00} == REG_CTRL) && wstrb_ff[0])
    begin
      ctrl_hold_ff <= wdata_ff[CTRL_HOLD_BIT];
    end
  end

  // read decode
  always_comb
  begin
    read_word = 32'h0000_0000;
    read_resp = RESP_OKAY;
    case ({s_axi_araddr[7:2], 2'b00})
      REG_STATUS:
      begin
        read_word[ST_FULL_N_BIT] = full_n_ff;
        read_word[ST_EMPTY_N_BIT] = empty_n_ff;
        read_word[ST_HALF_BIT] = half_ff;
        read_word[ST_NEAR_BIT] = near_ff;
        read_word[ST_RESET_BIT] = in_reset;
        read_word[ST_COUNT_LSB +: PTR_W] = fill_now;
      end
      REG_CTRL: read_word[CTRL_HOLD_BIT] = ctrl_hold_ff;
      REG_OFFSET:
      begin
        read_word[OFS_ACTIVE_LSB +: OFFSET_W] = offset_active_ff;
        read_word[OFS_CAND_LSB +: OFFSET_W] = candidate_ff;
      end
      default: read_resp = RESP_SLVERR;
    endcase
  end

  // read answer held until the master takes it
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_ff <= 1'b1;
      rdata_ff <= read_word;
      rresp_ff <= read_resp;
    end
    else if (s_axi_rready)
    begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

endmodule // dual_clock_fifo_1024x18

`default_nettype wire

// file: rtl/fifo_mem.sv
// word memory of the buffer with registered read data
// assumes write and read addresses are steady from flops on clk
`timescale 1ns/1ps
`default_nettype none

module fifo_mem
  import fifo_pkg::*;
(
  // clock
  input wire logic clk,
  // storage port
  mem_if.store port
);

  logic [DATA_W-1:0] ram [DEPTH];

  // word store on accepted writes
  always_ff @(posedge clk)
  begin
    if (port.we)
    begin
      ram[port.waddr] <= port.wdata;
    end
  end

  // head word read every cycle; left unreset on purpose
  always_ff @(posedge clk)
  begin
    port.rdata <= ram[port.raddr];
  end

endmodule // fifo_mem

`default_nettype wire

// file: rtl/fifo_pkg.sv
// shared constants, types and helpers for the 1024 x 18 sampled-clock buffer
// assumes a single system clock samples every pin of the buffer

package fifo_pkg;

  // ****************************************************************
  // geometry
  // ****************************************************************
  localparam int unsigned DATA_W = 18;
  localparam int unsigned DEPTH = 1024;
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned PTR_W = 11;
  localparam int unsigned OFFSET_W = 9;

  // fill levels used by the flags
  localparam logic [10:0] FULL_LEVEL = 11'h400;
  localparam logic [10:0] HALF_LEVEL = 11'h200;
  localparam logic [8:0] DEFAULT_OFFSET = 9'h100;

  // ****************************************************************
  // control pin vector positions and reset value
  // ****************************************************************
  localparam int unsigned PIN_WCLK = 0;
  localparam int unsigned PIN_RCLK = 1;
  localparam int unsigned PIN_RST_N = 2;
  localparam int unsigned PIN_STROBE_N = 3;
  localparam int unsigned PIN_OE = 4;
  localparam int unsigned PIN_COUNT = 5;
  localparam logic [4:0] PIN_LEVEL_RESET = 5'h00;

  // ****************************************************************
  // register map (byte addresses) and fields
  // ****************************************************************
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h04;
  localparam logic [7:0] REG_OFFSET = 8'h08;
  localparam int unsigned ST_FULL_N_BIT = 0;
  localparam int unsigned ST_EMPTY_N_BIT = 1;
  localparam int unsigned ST_HALF_BIT = 2;
  localparam int unsigned ST_NEAR_BIT = 3;
  localparam int unsigned ST_RESET_BIT = 4;
  localparam int unsigned ST_COUNT_LSB = 16;
  localparam int unsigned CTRL_HOLD_BIT = 0;
  localparam int unsigned OFS_ACTIVE_LSB = 0;
  localparam int unsigned OFS_CAND_LSB = 16;
  localparam logic CTRL_HOLD_RESET = 1'b0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // buffer reset tracking
  typedef enum logic [0:0] {
    ST_RUN = 1'b0,
    ST_RESET = 1'b1
  } reset_state_e;

  // words held, modulo pointer width
  function automatic logic [10:0] fill_count(input logic [10:0] wr, input logic [10:0] rd);
    fill_count = wr - rd;
  endfunction

endpackage

// file: rtl/mem_if.sv
// storage port between buffer control and its word memory
// assumes both ends run on the same system clock
`timescale 1ns/1ps
`default_nettype none

interface mem_if;
  import fifo_pkg::*;
  logic we;
  logic [ADDR_W-1:0] waddr;
  logic [DATA_W-1:0] wdata;
  logic [ADDR_W-1:0] raddr;
  logic [DATA_W-1:0] rdata;

  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

`default_nettype wire

// file: rtl/pin_sync.sv
// three-stage sampler for pins that change outside clk
// assumes rst is synchronous to clk
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pin side
  input wire logic [W-1:0] pin_in,
  // sampled stages
  output logic [W-1:0] stage2,
  output logic [W-1:0] stage3
);

  logic [W-1:0] stage1_ff;

  // first stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stage1_ff <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end
    else
    begin
      stage1_ff <= pin_in;
      stage2 <= stage1_ff;
      stage3 <= stage2;
    end
  end

endmodule // pin_sync

`default_nettype wire

// file: verif/dual_clock_fifo_1024x18_chk.sv
// concurrent checks on the buffer's top-level ports
// assumes it is bound into the buffer top and shares its clk and rst
`timescale 1ns/1ps
`default_nettype none

module dual_clock_fifo_1024x18_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // buffer pins
  input wire logic write_clock,
  input wire logic fifo_reset_n,
  input wire logic output_enable,
  input wire logic read_data_oe,
  input wire logic full_n,
  input wire logic empty_n,
  input wire logic half_level_flag,
  input wire logic near_limit_flag,
  // bus handshakes
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // a write edge seen while empty and out of reset
  sequence s_wr_edge;
    $rose(write_clock) && !empty_n && fifo_reset_n;
  endsequence
  // first word falls through with no read edge
  sequence s_shows;
    ##[1:12] empty_n;
  endsequence

  a_first_word: assert property (s_wr_edge |-> s_shows)
    else $error("first word did not fall through");
  a_reset_levels: assert property (!fifo_reset_n [*6] |->
    full_n && !empty_n && !half_level_flag && near_limit_flag)
    else $error("flags not at reset levels");
  a_full_flags: assert property (!full_n |->
    half_level_flag && near_limit_flag && empty_n)
    else $error("flags disagree while full");
  a_empty_flags: assert property (!empty_n |-> !half_level_flag && full_n)
    else $error("flags disagree while empty");
  a_oe_off: assert property (!output_enable [*8] |-> !read_data_oe)
    else $error("read data driven while disabled");
  a_oe_on: assert property (output_enable [*8] |-> read_data_oe)
    else $error("read data not driven while enabled");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_read_clear: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  a_write_clear: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
endmodule // dual_clock_fifo_1024x18_chk

`default_nettype wire

// file: verif/dual_clock_fifo_1024x18_tb_top.sv
// self-checking bench of the 1024 x 18 buffer with its far-side model
// assumes clk at 10 MHz samples every buffer pin
`timescale 1ns/1ps
`default_nettype none

module dual_clock_fifo_1024x18_tb_top;
  import fifo_pkg::*;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic write_clock, read_clock, fifo_reset_n = 1'b0, offset_define_strobe_n = 1'b1;
  logic output_enable = 1'b1, read_data_oe, full_n, empty_n, half_level_flag, near_limit_flag;
  logic [17:0] write_data_in, read_data_out, din = 18'h00000;
  logic wr_go = 1'b0, rd_go = 1'b0, show = 1'b0, busy;
  int n_errors = 0;
  int compares = 0;
  // the pin as seen on the board: floats when not driven
  wire logic [17:0] q_pin = read_data_oe ? read_data_out : 'z;

  dual_clock_fifo_1024x18 dut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .write_clock, .read_clock, .fifo_reset_n,
    .offset_define_strobe_n, .output_enable, .write_data_in, .read_data_out, .read_data_oe,
    .full_n, .empty_n, .half_level_flag, .near_limit_flag);
  fifo_far_model far (.clk, .wr_go, .rd_go, .show, .din, .write_clock, .read_clock,
    .write_data_in, .busy);

  // clock
  initial
  begin
    forever #50 clk = ~clk;
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic report_and_stop();
    if (n_errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic tmo();
    n_errors++;
    $display("ERROR %0t wait ran out", $time);
    report_and_stop();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // word pattern that differs in every count
  function automatic logic [17:0] wd(input int i);
    wd = {i[9:0], ~i[7:0]};
  endfunction

  // one write or read frame on the pins, then settle
  task automatic frame(input logic wr, input logic [17:0] d);
    int n;
    logic seen;
    seen = 1'b0;
    din <= d;
    wr_go <= wr;
    rd_go <= !wr;
    for (n = 0; n < 40 && !(seen && !busy); n++)
    begin
      @(posedge clk);
      wr_go <= 1'b0;
      rd_go <= 1'b0;
      seen = seen | busy;
    end
    if (n == 40)
      tmo();
    repeat (4) @(posedge clk);
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
        break;
    end
    s_axi_bready <= 1'b0;
    if (n == 20)
      tmo();
    chk(s_axi_bresp, r);
    // let an edge pass so a following call never reassigns bready in this step
    @(posedge clk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
        break;
    end
    s_axi_rready <= 1'b0;
    if (n == 20)
      tmo();
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    chk(rd, e);
    chk(rr, r);
    @(posedge clk);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    chk({full_n, empty_n, half_level_flag, near_limit_flag}, 4'h9);
    fifo_reset_n <= 1'b1;
    repeat (10) @(posedge clk);
    rchk(REG_OFFSET, 32'h01000100, RESP_OKAY);
    rchk(REG_CTRL, 32'h00000000, RESP_OKAY);
    rchk(REG_STATUS, 32'h00000009, RESP_OKAY);
    rchk(8'h0C, 32'h00000000, RESP_SLVERR);
    axw(REG_STATUS, 32'hFFFFFFFF, RESP_OKAY);
    axw(8'h0C, 32'h00000001, RESP_SLVERR);
    rchk(REG_STATUS, 32'h00000009, RESP_OKAY);
  endtask

  task automatic t_fall();
    frame(1'b1, 18'h2A5A5);
    chk(empty_n, 1'b1);
    chk(read_data_out, 18'h2A5A5);
    frame(1'b0, 18'h00000);
    chk(empty_n, 1'b0);
    frame(1'b0, 18'h00000);
    chk(empty_n, 1'b0);
    output_enable <= 1'b0;
    repeat (10) @(posedge clk);
    chk({14'h0000, q_pin}, {14'h0000, {18{1'bz}}});
    output_enable <= 1'b1;
    repeat (10) @(posedge clk);
  endtask

  task automatic t_fill();
    int k;
    for (k = 1; k <= 1024; k++)
    begin
      frame(1'b1, wd(k));
      chk(half_level_flag, k >= 512);
      chk(near_limit_flag, k <= 256 || k >= 768);
      chk(full_n, k != 1024);
    end
    frame(1'b1, 18'h3FFFF);
    rchk(REG_STATUS, 32'h0400000E, RESP_OKAY);
    for (k = 1; k <= 1024; k++)
    begin
      chk(read_data_out, wd(k));
      frame(1'b0, 18'h00000);
      chk(empty_n, k != 1024);
    end
  endtask

  task automatic t_offset();
    int k;
    din <= 18'h20005;
    show <= 1'b1;
    repeat (4) @(posedge clk);
    offset_define_strobe_n <= 1'b0;
    repeat (6) @(posedge clk);
    fifo_reset_n <= 1'b0;
    repeat (10) @(posedge clk);
    fifo_reset_n <= 1'b1;
    repeat (10) @(posedge clk);
    rchk(REG_OFFSET, 32'h00050005, RESP_OKAY);
    din <= 18'h000AA;
    offset_define_strobe_n <= 1'b1;
    repeat (6) @(posedge clk);
    offset_define_strobe_n <= 1'b0;
    repeat (6) @(posedge clk);
    show <= 1'b0;
    rchk(REG_OFFSET, 32'h00AA0005, RESP_OKAY);
    for (k = 1; k <= 6; k++)
    begin
      frame(1'b1, wd(k));
      chk(near_limit_flag, k <= 5);
    end
  endtask

  // software hold acts as a reset cycle; strobe high picks the default
  task automatic t_hold();
    offset_define_strobe_n <= 1'b1;
    repeat (6) @(posedge clk);
    axw(REG_CTRL, 32'h00000001, RESP_OKAY);
    repeat (6) @(posedge clk);
    rchk(REG_STATUS, 32'h00000019, RESP_OKAY);
    axw(REG_CTRL, 32'h00000000, RESP_OKAY);
    repeat (6) @(posedge clk);
    rchk(REG_OFFSET, 32'h00AA0100, RESP_OKAY);
  endtask

  // write and read pin clocks rising on the same clk edge
  task automatic t_both();
    frame(1'b1, wd(1));
    din <= wd(2);
    wr_go <= 1'b1;
    rd_go <= 1'b1;
    @(posedge clk);
    wr_go <= 1'b0;
    rd_go <= 1'b0;
    repeat (20) @(posedge clk);
    chk(read_data_out, wd(2));
    chk(empty_n, 1'b1);
  endtask

  // main sequence
  initial
  begin
    t_reset();
    t_fall();
    t_fill();
    t_offset();
    t_hold();
    t_both();
    report_and_stop();
  end
endmodule // dual_clock_fifo_1024x18_tb_top

bind dual_clock_fifo_1024x18 dual_clock_fifo_1024x18_chk chk_i (.clk, .rst, .write_clock,
  .fifo_reset_n, .output_enable, .read_data_oe, .full_n, .empty_n, .half_level_flag,
  .near_limit_flag, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready);

`default_nettype wire

// file: verif/fifo_far_model.sv
// far side of the buffer pins: a writing agent and a reading agent
// assumes the bench asks for one frame per agent at a time with a one-cycle go
`timescale 1ns/1ps
`default_nettype none

module fifo_far_model (
  // clock
  input wire logic clk,
  // bench requests
  input wire logic wr_go,
  input wire logic rd_go,
  input wire logic show,
  input wire logic [17:0] din,
  // pins toward the buffer, and busy back to the bench
  output logic write_clock,
  output logic read_clock,
  output logic [17:0] write_data_in,
  output logic busy
);
  // ****************************************************************
  // frames of 12 clk, pin clock high for 4 clk, still between frames
  // ****************************************************************
  logic [3:0] wcnt_ff = 4'h0;
  logic [3:0] rcnt_ff = 4'h0;
  logic [17:0] d_ff = 18'h00000;

  // write frame counter and data latch
  always_ff @(posedge clk)
  begin
    if (wr_go || wcnt_ff != 4'h0)
      wcnt_ff <= (wcnt_ff == 4'hB) ? 4'h0 : wcnt_ff + 4'h1;
    if ((wr_go && wcnt_ff == 4'h0) || show)
      d_ff <= din;
  end

  // read frame counter
  always_ff @(posedge clk)
  begin
    if (rd_go || rcnt_ff != 4'h0)
      rcnt_ff <= (rcnt_ff == 4'hB) ? 4'h0 : rcnt_ff + 4'h1;
  end

  // data stands well past the edge; outside a frame it flips, unless show holds it, so stale data never matches
  assign write_clock = wcnt_ff >= 4'h3 && wcnt_ff <= 4'h6;
  assign read_clock = rcnt_ff >= 4'h3 && rcnt_ff <= 4'h6;
  assign write_data_in = (wcnt_ff != 4'h0 || show) ? d_ff : ~d_ff;
  assign busy = wcnt_ff != 4'h0 || rcnt_ff != 4'h0;
endmodule // fifo_far_model

`default_nettype wire
